// ### rsc_adc_model.sv
// Behavioural strap converter answering the sequencer's conversion requests
`timescale 1ns/1ps
module rsc_adc_model #(
    parameter int unsigned LAT = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Request
    input wire logic adc_start,
    input wire logic adc_sel_freq,
    // Strap readings to return
    input wire logic [9:0] addr_code,
    input wire logic [9:0] freq_code,
    // Answer
    output logic [9:0] adc_data,
    output logic adc_done
);
    int unsigned cnt_ff;
    logic sel_ff;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 0;
            sel_ff <= 1'b0;
            adc_done <= 1'b0;
            adc_data <= 10'h155;
        end else begin
            adc_done <= 1'b0;
            // Data toggles outside the done cycle so a late sample cannot pass
            adc_data <= ~adc_data;
            if (adc_start) begin
                cnt_ff <= LAT;
                sel_ff <= adc_sel_freq;
            end else if (cnt_ff == 1) begin
                adc_done <= 1'b1;
                adc_data <= sel_ff ? freq_code : addr_code;
                cnt_ff <= 0;
            end else if (cnt_ff != 0) begin
                cnt_ff <= cnt_ff - 1;
            end
        end
    end
endmodule : rsc_adc_model

// ### rsc_checker.sv
// Port assertions for the regulator start-up sequencer
`timescale 1ns/1ps
module rsc_checker
    import rsc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Watched inputs
    input wire rsc_pkg::rsc_cmp_type cmp_in,
    input wire logic hs_pulse,
    // Watched outputs
    input wire logic adc_start,
    input wire logic adc_sel_freq,
    input wire logic init_done,
    input wire logic digital_mode,
    input wire logic [6:0] i2c_addr,
    input wire logic [6:0] pmbus_addr,
    input wire logic i2c_enable,
    input wire logic pmbus_enable,
    input wire logic pins_analog,
    input wire logic conv_enable,
    input wire logic [2:0] ls_eighths,
    input wire logic ls_allow,
    input wire logic [9:0] ref_level,
    input wire logic ramp_done,
    input wire logic prot_active
);
    logic [1:0] addr_rd_ff;
    logic [1:0] freq_rd_ff;
    logic hs_seen_ff;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Counters saturate so a fourth read cannot wrap back to a legal count
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_rd_ff <= 2'h0;
            freq_rd_ff <= 2'h0;
        end else if (adc_start && addr_rd_ff != 2'h3 && freq_rd_ff != 2'h3) begin
            addr_rd_ff <= addr_rd_ff + {1'b0, !adc_sel_freq};
            freq_rd_ff <= freq_rd_ff + {1'b0, adc_sel_freq};
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_seen_ff <= 1'b0;
        end else if (hs_pulse) begin
            hs_seen_ff <= 1'b1;
        end
    end
    a_one_addr_read: assert property (addr_rd_ff <= 2'h1) else $error("address strap re-read");
    a_one_freq_read: assert property (freq_rd_ff <= 2'h1) else $error("frequency strap re-read");
    a_bus_needs_mode: assert property ((i2c_enable || pmbus_enable) |-> digital_mode && init_done)
        else $error("bus enabled outside digital mode");
    a_analog_quiet: assert property (pins_analog |-> !i2c_enable && !pmbus_enable && !digital_mode)
        else $error("bus active in analog mode");
    a_conv_after_init: assert property (conv_enable |-> init_done) else $error("conversion early");
    a_conv_gate: assert property ($rose(conv_enable) |-> $past(cmp_in.en_ok, 2) && $past(cmp_in.vin_on_ok, 2))
        else $error("conversion without enable or input level");
    a_ramp_after_init: assert property ((ref_level != 10'h000) |-> init_done)
        else $error("ramp before load");
    a_ls_after_hs: assert property (ls_allow |-> hs_seen_ff) else $error("low side before high side");
    a_ls_width_set: assert property (ls_allow |-> ls_eighths != 3'h0) else $error("zero low side width");
    a_ramp_full: assert property (ramp_done |-> ref_level == REF_FULL) else $error("ramp end not full");
    a_prot_on: assert property (prot_active) else $error("protection dropped");
    a_addr_held: assert property (init_done && $past(init_done, 3) |-> $stable(i2c_addr) && $stable(pmbus_addr))
        else $error("address changed after init");
endmodule : rsc_checker

bind rsc_top rsc_checker u_rsc_checker (.*);

// ### rsc_pkg.sv
// Package: constants and carrier types for the regulator start-up sequencer
package rsc_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned MS_CYC = CLK_MHZ * 1000;
    localparam logic [6:0] I2C_BASE_RST = 7'h10;
    localparam logic [6:0] PMBUS_BASE_RST = 7'h40;
    localparam int unsigned ADC_W = 10;
    localparam int unsigned NSTEP = 16;
    localparam logic [9:0] ADC_FLOAT_MIN = 10'h3F0;
    localparam logic [6:0] TON_DELAY_RST = 7'h00;
    localparam logic [6:0] TON_RISE_RST = 7'h02;
    localparam logic [6:0] ANALOG_RISE_MS = 7'h02;
    localparam logic [10:0] FSW_DIG_RST = 11'h25F;
    localparam logic [2:0] PB_FIRST_EIGHTHS = 3'h1;
    localparam logic [3:0] PB_CYC_PER_STEP = 4'hF;
    localparam logic [9:0] REF_FULL = 10'h3FF;

    typedef struct packed {
        logic [6:0] i2c_base;
        logic [6:0] pmbus_base;
        logic [6:0] ton_delay_ms;
        logic [6:0] ton_rise_ms;
        logic [10:0] fsw_khz;
    } rsc_cfg_type;

    typedef struct packed {
        logic en_ok;
        logic vin_on_ok;
        logic vin_off_trip;
        logic vin_ov;
        logic vin_uv_warn;
    } rsc_cmp_type;
endpackage : rsc_pkg

// ### rsc_top.sv
// Start-up, addressing and frequency selection logic of the buck regulator
`timescale 1ns/1ps
module rsc_top
    import rsc_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Nonvolatile store load port
    input wire rsc_pkg::rsc_cfg_type nvm_cfg,
    input wire logic nvm_valid,
    // Converter for strap pins
    output logic adc_start,
    output logic adc_sel_freq,
    input wire logic [9:0] adc_data,
    input wire logic adc_done,
    // Run-time writes from the bus engine
    input wire logic cfg_wr,
    input wire rsc_pkg::rsc_cfg_type cfg_wdata,
    // Analog comparators
    input wire rsc_pkg::rsc_cmp_type cmp_in,
    input wire logic ocp_trip,
    input wire logic ovp_trip,
    // Power stage pulses
    input wire logic hs_pulse,
    input wire logic period_start,
    // Status and controls
    output logic init_done,
    output logic digital_mode,
    output logic [6:0] i2c_addr,
    output logic [6:0] pmbus_addr,
    output logic i2c_enable,
    output logic pmbus_enable,
    output logic pins_analog,
    output logic conv_enable,
    output logic [2:0] ls_eighths,
    output logic ls_allow,
    output logic [9:0] ref_level,
    output logic ramp_done,
    output logic [10:0] fsw_khz,
    output logic prot_active
);
    import rsc_pkg::*;

    typedef enum {S_LOAD, S_ADDR, S_FREQ, S_RUN} rsc_init_type;
    typedef enum {P_OFF, P_DELAY, P_RAMP, P_ON} rsc_pwr_type;

    // Midpoint decision thresholds between adjacent nominal strap codes
    localparam logic [9:0] STRAP_TH [15] = '{10'h020, 10'h058, 10'h078, 10'h098,
        10'h0B8, 10'h0D8, 10'h0F8, 10'h11C, 10'h144, 10'h170, 10'h19C, 10'h1CC,
        10'h1FC, 10'h230, 10'h268};
    localparam logic [10:0] FSW_TAB [16] = '{11'd306, 11'd356, 11'd400, 11'd444,
        11'd500, 11'd550, 11'd600, 11'd706, 11'd750, 11'd800, 11'd923, 11'd1000,
        11'd1091, 11'd1200, 11'd1333, 11'd1500};

    rsc_init_type init_ff;
    rsc_pwr_type pwr_ff;
    rsc_cfg_type cfg_ff;
    rsc_cmp_type cmp_m_ff, cmp_a_ff, cmp_b_ff;
    logic [3:0] addr_off_ff;
    logic [31:0] ms_cnt_ff;
    logic [6:0] ms_num_ff;
    logic [6:0] rise_ms_ff;
    logic [9:0] ref_ff;
    logic [31:0] ref_acc_ff;
    logic hs_seen_ff;
    logic [3:0] pb_cyc_ff;
    logic [2:0] ls_ff;
    logic adc_pend_ff;
    logic [3:0] strap_step;
    logic [15:0] th_hit;
    logic run_ok;
    logic ocp_m_ff, ocp_a_ff, ocp_b_ff;
    logic addr_held_ff;
    logic [31:0] ramp_len;

    // Quantize to nearest step: count thresholds at or below the reading
    genvar gi;
    generate
        for (gi = 0; gi < 15; gi = gi + 1) begin : g_th
            assign th_hit[gi] = (adc_data >= STRAP_TH[gi]);
        end
    endgenerate
    assign th_hit[15] = 1'b0;

    always_comb begin
        strap_step = 4'h0;
        for (int i = 0; i < 15; i++) begin
            if (th_hit[i]) begin
                strap_step = 4'(i + 1);
            end
        end
    end

    // Comparator levels come from analog blocks: three-stage synchronizer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmp_m_ff <= '0;
            cmp_a_ff <= '0;
            cmp_b_ff <= '0;
            ocp_m_ff <= 1'b0;
            ocp_a_ff <= 1'b0;
            ocp_b_ff <= 1'b0;
        end else begin
            cmp_m_ff <= cmp_in;
            cmp_a_ff <= cmp_m_ff;
            cmp_b_ff <= cmp_a_ff;
            ocp_m_ff <= ocp_trip;
            ocp_a_ff <= ocp_m_ff;
            ocp_b_ff <= ocp_a_ff;
        end
    end

    // Enable and UVLO threshold are comparator outputs; telemetry never gates this
    assign run_ok = (cmp_a_ff.en_ok & cmp_b_ff.en_ok) & (cmp_a_ff.vin_on_ok & cmp_b_ff.vin_on_ok)
        & ~(cmp_a_ff.vin_ov & cmp_b_ff.vin_ov);
    // Ramp length in clock cycles; a zero rise setting counts as one millisecond
    assign ramp_len = 32'(MS_CYCLES) * 32'((rise_ms_ff == 7'h00) ? 7'h01 : rise_ms_ff);

    // Initialization sequence
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_ff <= S_LOAD;
            adc_pend_ff <= 1'b0;
            adc_start <= 1'b0;
            adc_sel_freq <= 1'b0;
            addr_off_ff <= 4'h0;
            digital_mode <= 1'b0;
            pins_analog <= 1'b0;
            init_done <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            case (init_ff)
                S_LOAD: begin
                    if (nvm_valid) begin
                        init_ff <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    if (!adc_pend_ff) begin
                        adc_start <= 1'b1;
                        adc_pend_ff <= 1'b1;
                        adc_sel_freq <= 1'b0;
                    end else if (adc_done) begin
                        adc_pend_ff <= 1'b0;
                        if (adc_data >= ADC_FLOAT_MIN) begin
                            pins_analog <= 1'b1;
                            init_ff <= S_FREQ;
                        end else begin
                            addr_off_ff <= strap_step;
                            digital_mode <= 1'b1;
                            init_ff <= S_RUN;
                            init_done <= 1'b1;
                        end
                    end
                end
                S_FREQ: begin
                    if (!adc_pend_ff) begin
                        adc_start <= 1'b1;
                        adc_pend_ff <= 1'b1;
                        adc_sel_freq <= 1'b1;
                    end else if (adc_done) begin
                        adc_pend_ff <= 1'b0;
                        init_ff <= S_RUN;
                        init_done <= 1'b1;
                    end
                end
                S_RUN: begin
                    init_ff <= S_RUN;
                end
                default: init_ff <= S_LOAD;
            endcase
        end
    end

    // Working registers: loaded from store, writable only in digital mode
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff <= '{I2C_BASE_RST, PMBUS_BASE_RST, TON_DELAY_RST, TON_RISE_RST, FSW_DIG_RST};
        end else if (init_ff == S_LOAD && nvm_valid) begin
            cfg_ff <= nvm_cfg;
        end else if (init_ff == S_RUN && digital_mode && cfg_wr) begin
            cfg_ff <= cfg_wdata;
        end
    end

    // Addresses and frequency
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            i2c_addr <= '0;
            pmbus_addr <= '0;
            i2c_enable <= 1'b0;
            pmbus_enable <= 1'b0;
            fsw_khz <= FSW_DIG_RST;
            addr_held_ff <= 1'b0;
        end else begin
            // Latched one cycle after init so the strap offset is already in place
            addr_held_ff <= init_done;
            if (!addr_held_ff) begin
                i2c_addr <= 7'(cfg_ff.i2c_base + 7'(addr_off_ff));
                pmbus_addr <= 7'(cfg_ff.pmbus_base + 7'(addr_off_ff));
            end
            i2c_enable <= digital_mode && init_done && (cfg_ff.i2c_base != 7'h00);
            pmbus_enable <= digital_mode && init_done && (cfg_ff.pmbus_base != 7'h00);
            if (init_ff == S_FREQ && adc_pend_ff && adc_done) begin
                fsw_khz <= FSW_TAB[strap_step];
            end else if (digital_mode) begin
                fsw_khz <= cfg_ff.fsw_khz;
            end
        end
    end

    // Power sequence: enable, delay, linear reference ramp
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_ff <= P_OFF;
            ms_cnt_ff <= '0;
            ms_num_ff <= '0;
            rise_ms_ff <= ANALOG_RISE_MS;
            ref_acc_ff <= '0;
            ref_ff <= '0;
        end else if (!run_ok || !init_done) begin
            pwr_ff <= P_OFF;
            ms_cnt_ff <= '0;
            ms_num_ff <= '0;
            ref_acc_ff <= '0;
            ref_ff <= '0;
        end else begin
            case (pwr_ff)
                P_OFF: begin
                    rise_ms_ff <= digital_mode ? cfg_ff.ton_rise_ms : ANALOG_RISE_MS;
                    if (digital_mode && cfg_ff.ton_delay_ms != 7'h00) begin
                        pwr_ff <= P_DELAY;
                    end else begin
                        pwr_ff <= P_RAMP;
                    end
                end
                P_DELAY: begin
                    if (ms_cnt_ff == 32'(MS_CYCLES - 1)) begin
                        ms_cnt_ff <= '0;
                        ms_num_ff <= 7'(ms_num_ff + 7'h01);
                        if (7'(ms_num_ff + 7'h01) >= cfg_ff.ton_delay_ms) begin
                            pwr_ff <= P_RAMP;
                            ms_num_ff <= '0;
                        end
                    end else begin
                        ms_cnt_ff <= ms_cnt_ff + 32'h1;
                    end
                end
                P_RAMP: begin
                    // One code step each time the accumulated slope passes the ramp length
                    if (ref_ff == REF_FULL) begin
                        pwr_ff <= P_ON;
                    end else if (ref_acc_ff + 32'(REF_FULL) >= ramp_len) begin
                        ref_acc_ff <= ref_acc_ff + 32'(REF_FULL) - ramp_len;
                        // Ramps shorter than one cycle per code jump straight to full scale
                        ref_ff <= (ramp_len >= 32'(REF_FULL)) ? 10'(ref_ff + 10'h001)
                            : REF_FULL;
                    end else begin
                        ref_acc_ff <= ref_acc_ff + 32'(REF_FULL);
                    end
                end
                P_ON: pwr_ff <= P_ON;
                default: pwr_ff <= P_OFF;
            endcase
        end
    end

    // Pre-bias: low side held off until first high-side pulse, then widened
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_seen_ff <= 1'b0;
            pb_cyc_ff <= 4'h0;
            ls_ff <= PB_FIRST_EIGHTHS;
        end else if (pwr_ff == P_OFF) begin
            hs_seen_ff <= 1'b0;
            pb_cyc_ff <= 4'h0;
            ls_ff <= PB_FIRST_EIGHTHS;
        end else if (hs_pulse && !hs_seen_ff) begin
            hs_seen_ff <= 1'b1;
        end else if (hs_seen_ff && period_start && ls_ff != 3'h7) begin
            pb_cyc_ff <= 4'(pb_cyc_ff + 4'h1);
            if (pb_cyc_ff == PB_CYC_PER_STEP) begin
                ls_ff <= 3'(ls_ff + 3'h1);
            end
        end
    end

    // Registered outputs of the power path
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_enable <= 1'b0;
            ls_allow <= 1'b0;
            ls_eighths <= '0;
            ref_level <= '0;
            ramp_done <= 1'b0;
            prot_active <= 1'b1;
        end else begin
            conv_enable <= (pwr_ff != P_OFF);
            ls_allow <= hs_seen_ff && !(ocp_a_ff && ocp_b_ff);
            ls_eighths <= ls_ff;
            ref_level <= ref_ff;
            ramp_done <= (pwr_ff == P_ON);
            // Protection is never masked by sequencing state
            prot_active <= 1'b1;
        end
    end
endmodule : rsc_top

// ### tb_top.sv
// Self-checking bench for the regulator start-up sequencer
`timescale 1ns/1ps
module tb_top;
    import rsc_pkg::*;
    typedef struct {logic [9:0] strap; logic [9:0] freq; logic dig; logic [10:0] fsw;
        logic [6:0] i2c;} row_type;
    localparam rsc_cfg_type DCFG = '{I2C_BASE_RST, PMBUS_BASE_RST, 7'h01, 7'h01, FSW_DIG_RST};
    row_type rows[5] = '{'{10'h000, 10'h000, 1'b1, 11'h25F, 7'h10},
        '{10'h060, 10'h000, 1'b1, 11'h25F, 7'h12}, '{10'h3E0, 10'h000, 1'b1, 11'h25F, 7'h1F},
        '{10'h3F0, 10'h0B8, 1'b0, 11'h226, 7'h10}, '{10'h3FF, 10'h3FF, 1'b0, 11'h5DC, 7'h10}};
    logic ref_clk = 0, arst_n = 0, nvm_valid = 0, cfg_wr = 0, hs_pulse = 0, period_start = 0;
    logic ocp_trip = 0, ovp_trip = 0;
    rsc_cfg_type nvm_cfg = DCFG, cfg_wdata = DCFG;
    rsc_cmp_type cmp_in = '0;
    logic [9:0] addr_code = 10'h000, freq_code = 10'h000, adc_data, ref_level;
    logic adc_start, adc_sel_freq, adc_done, init_done, digital_mode, i2c_enable, pmbus_enable;
    logic pins_analog, conv_enable, ls_allow, ramp_done, prot_active;
    logic [6:0] i2c_addr, pmbus_addr;
    logic [2:0] ls_eighths;
    logic [10:0] fsw_khz;
    int err_count = 0, tests_run = 0, cyc = 0, ramp_cyc = 0;
    rsc_top #(.MS_CYCLES(1024)) u_rsc_top (.ref_clk(ref_clk), .arst_n(arst_n), .nvm_cfg(nvm_cfg),
        .nvm_valid(nvm_valid), .adc_start(adc_start), .adc_sel_freq(adc_sel_freq),
        .adc_data(adc_data), .adc_done(adc_done), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .cmp_in(cmp_in), .ocp_trip(ocp_trip), .ovp_trip(ovp_trip), .hs_pulse(hs_pulse),
        .period_start(period_start), .init_done(init_done), .digital_mode(digital_mode),
        .i2c_addr(i2c_addr), .pmbus_addr(pmbus_addr), .i2c_enable(i2c_enable),
        .pmbus_enable(pmbus_enable), .pins_analog(pins_analog), .conv_enable(conv_enable),
        .ls_eighths(ls_eighths), .ls_allow(ls_allow), .ref_level(ref_level),
        .ramp_done(ramp_done), .fsw_khz(fsw_khz), .prot_active(prot_active));
    rsc_adc_model #(.LAT(3)) u_rsc_adc_model (.ref_clk(ref_clk), .arst_n(arst_n),
        .adc_start(adc_start), .adc_sel_freq(adc_sel_freq), .addr_code(addr_code),
        .freq_code(freq_code), .adc_data(adc_data), .adc_done(adc_done));
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        // Seven boots plus a 1 ms delay and a 1 ms ramp of 1024 cycles each
        if (cyc == 4000) begin
            err_count++;
            end_sim();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
            err_count++;
        end
    endtask : chk
    task boot(input logic [9:0] s, input rsc_cfg_type c);
        arst_n = 0;
        nvm_valid = 0;
        addr_code = s;
        nvm_cfg = c;
        cmp_in = '0;
        repeat (5) @(negedge ref_clk);
        chk("fsw_rst", 11'h25F, fsw_khz);
        arst_n = 1;
        @(negedge ref_clk);
        nvm_valid = 1;
        for (int i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge ref_clk);
        // Analog start needs a second conversion before the frequency settles
        repeat (12) @(negedge ref_clk);
    endtask : boot
    task per(input int n);
        repeat (n) begin
            period_start = 1;
            @(negedge ref_clk);
            period_start = 0;
            repeat (3) @(negedge ref_clk);
        end
    endtask : per
    task end_sim;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        foreach (rows[i]) begin
            freq_code = rows[i].freq;
            boot(rows[i].strap, DCFG);
            chk("digital", rows[i].dig, digital_mode);
            chk("analog", !rows[i].dig, pins_analog);
            chk("i2c_en", rows[i].dig, i2c_enable);
            chk("fsw", rows[i].fsw, fsw_khz);
            if (rows[i].dig) begin
                chk("i2c_off_addr", rows[i].i2c, i2c_addr);
                chk("pmb_off_addr", rows[i].i2c + 7'h30, pmbus_addr);
            end
        end
        cfg_wdata.fsw_khz = 11'h3E8;
        cfg_wdata.i2c_base = 7'h20;
        freq_code = 10'h000;
        cfg_wr = 1;
        @(negedge ref_clk);
        cfg_wr = 0;
        repeat (20) @(negedge ref_clk);
        chk("fsw_fixed", 11'h5DC, fsw_khz);
        boot(10'h000, '{7'h00, PMBUS_BASE_RST, 7'h01, 7'h01, FSW_DIG_RST});
        chk("i2c_off", 0, i2c_enable);
        chk("pmb_on", 1, pmbus_enable);
        boot(10'h000, DCFG);
        chk("i2c_addr", 7'h10, i2c_addr);
        chk("pmb_addr", 7'h40, pmbus_addr);
        cfg_wr = 1;
        @(negedge ref_clk);
        cfg_wr = 0;
        repeat (3) @(negedge ref_clk);
        chk("fsw_wr", 11'h3E8, fsw_khz);
        chk("i2c_held", 7'h10, i2c_addr);
        cmp_in.en_ok = 1;
        cmp_in.vin_on_ok = 1;
        for (int i = 0; i < 20 && conv_enable !== 1'b1; i++) @(negedge ref_clk);
        chk("conv_on", 1, conv_enable);
        per(2);
        chk("ls_off", 0, ls_allow);
        hs_pulse = 1;
        @(negedge ref_clk);
        hs_pulse = 0;
        per(2);
        chk("ls_on", 1, ls_allow);
        chk("ls_first", 3'h1, ls_eighths);
        per(13);
        chk("ls_hold", 3'h1, ls_eighths);
        per(1);
        chk("ls_step", 3'h2, ls_eighths);
        // Still inside the 1 ms start delay
        repeat (900) @(negedge ref_clk);
        chk("ref_delay", 10'h000, ref_level);
        repeat (560) @(negedge ref_clk);
        chk("ref_mid", 1, ref_level > 10'h100 && ref_level < 10'h300);
        chk("ramp_mid", 0, ramp_done);
        chk("prot", 1, prot_active);
        while (ramp_cyc < 600 && ramp_done !== 1'b1) begin
            ramp_cyc++;
            @(negedge ref_clk);
        end
        chk("ramp_len", 1, ramp_cyc > 480 && ramp_cyc < 560);
        chk("ramp_done", 1, ramp_done);
        chk("ref_full", REF_FULL, ref_level);
        cmp_in.en_ok = 0;
        for (int i = 0; i < 20 && conv_enable !== 1'b0; i++) @(negedge ref_clk);
        chk("conv_off", 0, conv_enable);
        end_sim();
    end
endmodule : tb_top
